// File: internal_osc_block_ctrl.sv
`timescale 1ns/10ps
`include "osc_block_defines.svh"
//
// Contract
// - fast clock 8 MHz drives clock directly or feeds postscaler, 31 kHz to 4 MHz
// - fast oscillator enabled for selections 125 kHz through 8 MHz, and for 31 kHz when tuning bit 7 is set
// - rc oscillator runs when selected or timer, monitor, watchdog, two-speed enabled
// - frequency select field chooses fast direct, rc direct or postscaler tap
// - select 111 is 8 MHz, 110 is 4 MHz, 101 is 2 MHz; reset 1 MHz
// - clkout mode: out pin gives clock divided by 4, in pin is port bit 7
// - pins io mode: in pin port bit 7, out pin port bit 6
// - trim write shifts fast oscillator only, uniform step, rc unaffected
// - fast oscillator settles within 1 ms, no completion flag
// - 5-bit signed trim: 01111 max, 0 centre, 10000 min
// - tuning bit 6 switches 4x multiplier, up to 32 MHz
// - multiplier only with primary config 1001 or 1000
// - multiplier also needs select 111 or 110
// - enable bit forced 0, ignores writes, reads 0 when unavailable
// - tuning bit 7 picks source for the 31 kHz option
// - bit set: fast divided by 256; clear: rc oscillator
module internal_osc_block_ctrl
  import osc_block_pkg::*;
(
  input wire logic clk, // 10 MHz clock
  input wire logic rst_n, // sync reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic portA6OutData, // port latch bit 6
  input wire logic portA6Dir_n, // port bit 6 drive, low drives
  input wire logic portA7OutData, // port latch bit 7
  input wire logic portA7Dir_n, // port bit 7 drive, low drives
  input wire logic oscPinInIn, // osc in pin level
  input wire logic oscPinOutIn, // osc out pin level
  output logic oscPinInOut, // osc in pin drive value
  output logic oscPinInOe_n, // osc in pin enable, low drives
  output logic oscPinOutOut, // osc out pin drive value
  output logic oscPinOutOe_n, // osc out pin enable, low drives
  output logic portA6In, // synced port bit 6 input
  output logic portA7In, // synced port bit 7 input
  output logic fastOscEnable, // fast oscillator run
  output logic lowPowerRcEnable, // rc oscillator run
  output logic [1:0] clkSource, // clk_source_t selection
  output logic [2:0] postscalerTap, // postscaler tap code
  output logic postscalerDiv256, // postscaler divide-by-256 tap
  output logic multiplierOn, // 4x multiplier run
  output logic [4:0] fastOscTrim, // signed trim to fast oscillator
  output logic fastOscSettling // trim shift in progress
);

  state_t st_r;
  state_t st_nxt;
  logic [1:0] a6Sync_r;
  logic [1:0] a7Sync_r;
  logic mulAvail;
  logic mulAllowedFreq;
  logic isWrite;
  logic isRead;
  logic addrOk;
  logic [7:0] tuningRead;

  // ---------------------------------------------------------------
  // pin input synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      a6Sync_r <= 2'h0;
      a7Sync_r <= 2'h0;
    end else begin
      a6Sync_r <= {a6Sync_r[0], oscPinOutIn};
      a7Sync_r <= {a7Sync_r[0], oscPinInIn};
    end
  end

  // ---------------------------------------------------------------
  // multiplier qualification
  // ---------------------------------------------------------------
  assign mulAvail = (st_r.oscConfig == `OSC_CFG_CLKOUT) ||
                    (st_r.oscConfig == `OSC_CFG_PINS_IO);
  assign mulAllowedFreq = (st_r.freqSel == `FSEL_8M) ||
                          (st_r.freqSel == `FSEL_4M);
  assign multiplierOn = st_r.mulEnable && mulAvail && mulAllowedFreq;

  assign isWrite = psel && penable && pwrite;
  assign isRead = psel && !pwrite;
  assign tuningRead = {st_r.srcSel, st_r.mulEnable & mulAvail, 1'b0,
                       st_r.trimValue};

  always_comb begin
    if (paddr == `ADDR_CONTROL) begin
      addrOk = 1'b1;
    end else if (paddr == `ADDR_TUNING) begin
      addrOk = 1'b1;
    end else if (paddr == `ADDR_STATUS) begin
      addrOk = 1'b1;
    end else if (paddr == `ADDR_CONFIG) begin
      addrOk = 1'b1;
    end else begin
      addrOk = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // fosc/4 for the clock-out pin
    st_nxt.div4Cnt = st_r.div4Cnt + 2'h1;
    if (st_r.div4Cnt[0]) begin
      st_nxt.clkOutDiv4 = ~st_r.clkOutDiv4;
    end
    if (st_r.settleCnt != 14'h0) begin
      st_nxt.settleCnt = st_r.settleCnt - 14'h1;
    end
    if (isWrite && addrOk) begin
      if (paddr == `ADDR_CONTROL) begin
        st_nxt.freqSel = pwdata[`CTL_FSEL_MSB:`CTL_FSEL_LSB];
      end else if (paddr == `ADDR_TUNING) begin
        st_nxt.srcSel = pwdata[`TUN_SRC_BIT];
        st_nxt.mulEnable = pwdata[`TUN_MUL_BIT] & mulAvail;
        st_nxt.trimValue = pwdata[`TUN_TRIM_MSB:`TUN_TRIM_LSB];
        st_nxt.settleCnt = 14'(`SETTLE_CYCLES);
      end else if (paddr == `ADDR_CONFIG) begin
        st_nxt.oscConfig = pwdata[`CFG_OSC_MSB:`CFG_OSC_LSB];
        st_nxt.pwrtEn = pwdata[`CFG_PWRT_BIT];
        st_nxt.fscmEn = pwdata[`CFG_FSCM_BIT];
        st_nxt.wdtEn = pwdata[`CFG_WDT_BIT];
        st_nxt.tssEn = pwdata[`CFG_TSS_BIT];
        if (!((pwdata[`CFG_OSC_MSB:`CFG_OSC_LSB] == `OSC_CFG_CLKOUT) ||
              (pwdata[`CFG_OSC_MSB:`CFG_OSC_LSB] == `OSC_CFG_PINS_IO))) begin
          st_nxt.mulEnable = 1'b0;
        end
      end
    end
    st_nxt.prdata = 32'h0;
    if (isRead) begin
      if (paddr == `ADDR_CONTROL) begin
        st_nxt.prdata = {25'h0, st_r.freqSel, 4'h0};
      end else if (paddr == `ADDR_TUNING) begin
        st_nxt.prdata = {24'h0, tuningRead};
      end else if (paddr == `ADDR_STATUS) begin
        // no completion flag for a trim shift: bit 7 reads 0
        st_nxt.prdata = {24'h0, 1'b0, multiplierOn, fastOscEnable,
                         lowPowerRcEnable, 2'h0, clkSource};
      end else if (paddr == `ADDR_CONFIG) begin
        st_nxt.prdata = {24'h0, st_r.tssEn, st_r.wdtEn, st_r.fscmEn, st_r.pwrtEn,
                         st_r.oscConfig};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.freqSel <= `FSEL_RESET;
      st_r.oscConfig <= `OSC_CFG_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // apb answers: read data registered in setup, one wait-free access
  // ---------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrOk;
  assign prdata = st_r.prdata;

  // ---------------------------------------------------------------
  // clock source selection
  // ---------------------------------------------------------------
  always_comb begin
    postscalerDiv256 = 1'b0;
    postscalerTap = st_r.freqSel;
    if (st_r.freqSel == `FSEL_8M) begin
      clkSource = 2'(SRC_FAST_DIRECT);
    end else if (st_r.freqSel == `FSEL_31K) begin
      if (st_r.srcSel) begin
        clkSource = 2'(SRC_POSTSCALER);
        postscalerDiv256 = 1'b1;
      end else begin
        clkSource = 2'(SRC_LOW_POWER_RC);
      end
    end else begin
      clkSource = 2'(SRC_POSTSCALER);
    end
  end

  assign fastOscEnable = (st_r.freqSel >= `FSEL_125K) ||
                         (st_r.freqSel == `FSEL_31K && st_r.srcSel);
  assign lowPowerRcEnable = (clkSource == 2'(SRC_LOW_POWER_RC)) || st_r.pwrtEn ||
                            st_r.fscmEn || st_r.wdtEn || st_r.tssEn;
  assign fastOscTrim = st_r.trimValue;
  assign fastOscSettling = st_r.settleCnt != 14'h0;

  // ---------------------------------------------------------------
  // oscillator pin assignment
  // ---------------------------------------------------------------
  always_comb begin
    oscPinInOut = 1'b0;
    oscPinInOe_n = 1'b1;
    oscPinOutOut = 1'b0;
    oscPinOutOe_n = 1'b1;
    if (st_r.oscConfig == `OSC_CFG_CLKOUT) begin
      oscPinOutOut = st_r.clkOutDiv4;
      oscPinOutOe_n = 1'b0;
      oscPinInOut = portA7OutData;
      oscPinInOe_n = portA7Dir_n;
    end else if (st_r.oscConfig == `OSC_CFG_PINS_IO) begin
      oscPinInOut = portA7OutData;
      oscPinInOe_n = portA7Dir_n;
      oscPinOutOut = portA6OutData;
      oscPinOutOe_n = portA6Dir_n;
    end
  end

  assign portA7In = a7Sync_r[1];
  assign portA6In = (st_r.oscConfig == `OSC_CFG_PINS_IO) ? a6Sync_r[1] : 1'b0;

endmodule : internal_osc_block_ctrl

// File: internal_osc_block_ctrl_sva.sv
`timescale 1ns/10ps
`include "osc_block_defines.svh"
module internal_osc_block_ctrl_sva (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic [11:0] paddr, // apb
  input wire logic [31:0] pwdata, // apb
  input wire logic fastOscEnable, // fast run
  input wire logic lowPowerRcEnable, // rc run
  input wire logic [1:0] clkSource, // source
  input wire logic [2:0] postscalerTap, // select
  input wire logic postscalerDiv256, // div tap
  input wire logic multiplierOn, // 4x run
  input wire logic [4:0] fastOscTrim // trim
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic tunWr;
  assign tunWr = psel && penable && pwrite && paddr == `ADDR_TUNING;
  fast_en_a: assert property (fastOscEnable == (postscalerTap != 3'h0 || postscalerDiv256))
    else $error("fast enable wrong");
  src_sel_a: assert property (clkSource == (postscalerTap == 3'h7 ? 2'h0 :
    (postscalerTap == 3'h0 && !postscalerDiv256) ? 2'h2 : 2'h1)) else $error("source wrong");
  div_tap_a: assert property (postscalerDiv256 |-> postscalerTap == 3'h0)
    else $error("div256 tap wrong");
  rc_run_a: assert property (clkSource == 2'h2 |-> lowPowerRcEnable)
    else $error("rc stopped");
  mul_sel_a: assert property (multiplierOn |-> postscalerTap[2:1] == 2'h3)
    else $error("multiplier at low select");
  mul_fast_a: assert property (multiplierOn |-> fastOscEnable && clkSource != 2'h2)
    else $error("multiplier without fast osc");
  trim_load_a: assert property (tunWr |=> fastOscTrim == $past(pwdata[4:0]))
    else $error("trim not loaded");
  trim_hold_a: assert property (!tunWr |=> $stable(fastOscTrim))
    else $error("trim moved");
endmodule : internal_osc_block_ctrl_sva

bind internal_osc_block_ctrl internal_osc_block_ctrl_sva u_sva (.clk, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .fastOscEnable, .lowPowerRcEnable, .clkSource, .postscalerTap,
  .postscalerDiv256, .multiplierOn, .fastOscTrim);

// File: internal_oscillator_block_ctrl_tb.sv
`timescale 1ns/10ps
`include "osc_block_defines.svh"
module internal_oscillator_block_ctrl_tb;
  localparam logic [32:0] allBits = '1;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [5:0] pins = 6'h00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pinInOut;
  logic pinInOe_n;
  logic pinOutOut;
  logic pinOutOe_n;
  logic [32:0] expQ[$];
  logic [32:0] mskQ[$];
  logic [32:0] e;
  logic [2:0] s;
  logic src;
  integer seed = 31;
  int n_errors = 0;
  int check_count = 0;
  int i;
  always #50 clk = ~clk;
  always @(posedge clk) pins <= 6'($random(seed));
  internal_osc_block_ctrl u_internal_osc_block_ctrl (.clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .portA6OutData(pins[0]), .portA6Dir_n(pins[1]),
    .portA7OutData(pins[2]), .portA7Dir_n(pins[3]), .oscPinInIn(pins[4]), .oscPinOutIn(pins[5]),
    .oscPinInOut(pinInOut), .oscPinInOe_n(pinInOe_n), .oscPinOutOut(pinOutOut),
    .oscPinOutOe_n(pinOutOe_n), .portA6In(), .portA7In(), .fastOscEnable(), .lowPowerRcEnable(),
    .clkSource(), .postscalerTap(), .postscalerDiv256(), .multiplierOn(), .fastOscTrim(),
    .fastOscSettling());
  task chk(input logic [32:0] got, input logic [32:0] x, input logic [32:0] m);
    check_count++;
    if (((got ^ x) & m) !== 33'h0) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, x);
    end
  endtask : chk
  task final_report;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (!pready) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [11:0] a, input logic [32:0] x, input logic [32:0] m);
    expQ.push_back(x);
    mskQ.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task pinchk(input logic co);
    int h;
    h = 0;
    repeat (8) begin
      @(negedge clk);
      h += pinOutOut;
      chk({pinInOut, pinInOe_n}, {pins[2], pins[3]}, 33'h3);
      chk({pinOutOut, pinOutOe_n}, co ? 33'h0 : {pins[0], pins[1]}, co ? 33'h1 : 33'h3);
    end
    if (co) chk(33'(h), 33'h4, allBits);
  endtask : pinchk
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite)
      chk({pslverr, prdata}, expQ.pop_front(), mskQ.pop_front());
  end
  initial begin
    #2000000;
    n_errors++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(`ADDR_CONTROL, 33'h40, allBits);
    rd(`ADDR_TUNING, 33'h0, allBits);
    rd(`ADDR_CONFIG, 33'h8, allBits);
    rd(12'h010, 33'h100000000, allBits);
    for (i = 0; i < 6; i++) begin
      e = (i == 0) ? 33'hF : (i == 1) ? 33'h10 : 33'($random(seed));
      apb(1'b1, `ADDR_TUNING, e[31:0]);
      rd(`ADDR_TUNING, e & 33'hDF, allBits);
    end
    apb(1'b1, `ADDR_TUNING, 32'h3);
    rd(`ADDR_TUNING, 33'h3, allBits);
    apb(1'b1, `ADDR_TUNING, 32'h2);
    rd(`ADDR_TUNING, 33'h2, allBits);
    rd(`ADDR_STATUS, 33'h0, 33'h80);
    for (i = 0; i < 16; i++) begin
      s = i[2:0];
      src = i[3];
      apb(1'b1, `ADDR_CONTROL, {25'h0, s, 4'h0});
      apb(1'b1, `ADDR_TUNING, {24'h0, src, 7'h40});
      e = {26'h0, s[2] & s[1], s != 3'h0 || src, s == 3'h0 && !src, 2'h0,
        s == 3'h7 ? 2'h0 : (s == 3'h0 && !src) ? 2'h2 : 2'h1};
      rd(`ADDR_STATUS, e, 33'h7F);
    end
    for (i = 4; i < 8; i++) begin
      apb(1'b1, `ADDR_CONFIG, 32'h8 | (32'h1 << i));
      rd(`ADDR_STATUS, 33'h10, 33'h10);
    end
    apb(1'b1, `ADDR_CONFIG, 32'h0);
    rd(`ADDR_STATUS, 33'h0, 33'h50);
    rd(`ADDR_TUNING, 33'h80, allBits);
    apb(1'b1, `ADDR_TUNING, 32'hC0);
    rd(`ADDR_TUNING, 33'h80, allBits);
    apb(1'b1, `ADDR_CONFIG, 32'h9);
    pinchk(1'b1);
    apb(1'b1, `ADDR_TUNING, 32'hC0);
    rd(`ADDR_STATUS, 33'h40, 33'h40);
    apb(1'b1, `ADDR_CONFIG, 32'h8);
    pinchk(1'b0);
    repeat (2) @(posedge clk);
    final_report();
  end
endmodule : internal_oscillator_block_ctrl_tb

// File: osc_block_defines.svh
`ifndef OSC_BLOCK_DEFINES_SVH
`define OSC_BLOCK_DEFINES_SVH

// register byte addresses
`define ADDR_CONTROL 12'h000
`define ADDR_TUNING 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_CONFIG 12'h00C

// control register fields
`define CTL_FSEL_LSB 4
`define CTL_FSEL_MSB 6
`define FSEL_RESET 3'h4
`define FSEL_8M 3'h7
`define FSEL_4M 3'h6
`define FSEL_2M 3'h5
`define FSEL_125K 3'h1
`define FSEL_31K 3'h0

// tuning register fields
`define TUN_SRC_BIT 7
`define TUN_MUL_BIT 6
`define TUN_TRIM_MSB 4
`define TUN_TRIM_LSB 0

// config register fields
`define CFG_OSC_LSB 0
`define CFG_OSC_MSB 3
`define CFG_PWRT_BIT 4
`define CFG_FSCM_BIT 5
`define CFG_WDT_BIT 6
`define CFG_TSS_BIT 7
`define OSC_CFG_CLKOUT 4'h9
`define OSC_CFG_PINS_IO 4'h8
`define OSC_CFG_RESET 4'h8

// timing
`define CLK_HZ 10000000
`define SETTLE_US 1000
`define SETTLE_CYCLES ((`SETTLE_US * (`CLK_HZ / 1000000)))
`define SETTLE_W 14

`endif

// File: osc_block_pkg.sv
package osc_block_pkg;
  `include "osc_block_defines.svh"

  typedef enum logic [1:0] {
    SRC_FAST_DIRECT,
    SRC_POSTSCALER,
    SRC_LOW_POWER_RC
  } clk_source_t;

  typedef struct packed {
    logic [2:0] freqSel;
    logic srcSel;
    logic mulEnable;
    logic [4:0] trimValue;
    logic [3:0] oscConfig;
    logic pwrtEn;
    logic fscmEn;
    logic wdtEn;
    logic tssEn;
    logic [13:0] settleCnt;
    logic [31:0] prdata;
    logic [1:0] div4Cnt;
    logic clkOutDiv4;
  } state_t;

  typedef struct packed {
    logic portA6Out;
    logic portA6Oe_n;
    logic portA7Out;
    logic portA7Oe_n;
  } port_drive_t;
endpackage : osc_block_pkg
